// ==== src/dim_pkg.sv ====
// Shared constants and types for the pulse-count LED dimming link
package dim_pkg;
  localparam int CLK_HZ         = 40_000_000;
  localparam int CYC_PER_US     = CLK_HZ / 1_000_000;
  localparam int LEVEL_W        = 5;
  localparam logic [4:0] LEVEL_FULL = 5'h1f;  // 31 mA
  localparam logic [4:0] LEVEL_OFF  = 5'h00;  // 0 mA
  localparam int PRIM_LEDS      = 4;
  localparam int SEC_LEDS       = 2;
  // Device timing
  localparam int MODE_DELAY_US  = 400;   // Wait before 1.5x mode
  localparam int SHDN_LOW_US    = 1500;  // Single-wire low that means shutdown
  localparam int MODE_DELAY_CYC = MODE_DELAY_US * CYC_PER_US;
  localparam int SHDN_LOW_CYC   = SHDN_LOW_US * CYC_PER_US;
  // Host timing
  localparam int PULSE_MAX_US   = 500;   // Longest legal pulse low time
  localparam int PULSE_LOW_US   = 10;
  localparam int PULSE_HIGH_US  = 10;
  localparam int SHDN_HOLD_US   = 2000;
  localparam int PULSE_LOW_CYC  = PULSE_LOW_US * CYC_PER_US;
  localparam int PULSE_HIGH_CYC = PULSE_HIGH_US * CYC_PER_US;
  localparam int SHDN_HOLD_CYC  = SHDN_HOLD_US * CYC_PER_US;
  localparam int CNT_W          = 17;
  // Host request codes
  typedef enum logic [1:0] {
    OP_ENABLE   = 2'h0,
    OP_PULSE_PR = 2'h1,
    OP_PULSE_SE = 2'h2,
    OP_SHUTDOWN = 2'h3
  } op_e;
endpackage

// ==== src/dim_if.sv ====
// Link between the host controller and the dimming device
`timescale 1ns/1ps
interface dim_if;
  logic enable;                   // Active-high enable
  logic primary_group_pulse_n;    // Primary group dimming pulses
  logic secondary_group_pulse_n;  // Secondary group dimming pulses
  modport host (output enable, output primary_group_pulse_n, output secondary_group_pulse_n);
  modport dev  (input enable, input primary_group_pulse_n, input secondary_group_pulse_n);
endinterface

// ==== src/dim_device.sv ====
// Dimming device end: input sampling, pulse counting, shutdown and mode selection
// Function
// (R1) Start in 1x mode while regulation holds
// (R2) Regulation loss moves to 1.5x after 400 us
// (R3) Restart in 1x on reset and enable
// (R4) Primary pulses drive four, secondary drive two
// (R5) Host enables before sending any pulses
// (R6) First falling edge sets full scale 31 mA
// (R7) Each further falling edge lowers 1 mA
// (R8) Thirty-second falling edge switches group off
// (R9) Enable low puts device in shutdown
// (R10) Host may tie all three inputs together
// (R11) Single-wire pulses stay low under 0.5 ms
// (R12) Single-wire low over 1.5 ms means shutdown
// (R13) Group settings clear on reset and shutdown
// (R14) Inputs synchronised, edges and lows timed on clock
`timescale 1ns/1ps
module dim_device
  import dim_pkg::*;
#(
  parameter int MODE_DELAY = MODE_DELAY_CYC,
  parameter int SHDN_LOW   = SHDN_LOW_CYC
) (
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  dim_if.dev                        LINK,
  input  wire logic                 SINGLE_WIRE,
  input  wire logic                 REG_SHORT,
  output logic [LEVEL_W-1:0]        PRIM_LEVEL,
  output logic [LEVEL_W-1:0]        SEC_LEVEL,
  output logic [PRIM_LEDS-1:0]      PRIMARY_LED_OUTPUTS,
  output logic [SEC_LEDS-1:0]       SECONDARY_LED_OUTPUTS,
  output logic                      MODE_1P5X,
  output logic                      SHUTDOWN
);

  typedef enum logic [3:0] {
    ST_SHDN = 4'h1,
    ST_1X   = 4'h2,
    ST_WAIT = 4'h4,
    ST_15X  = 4'h8
  } mode_e;

  mode_e              mode_q;
  mode_e              mode_d;
  logic [2:0]         sync1_q;
  logic [2:0]         sync2_q;
  logic [2:0]         prev_q;
  logic               short1_q;
  logic               short2_q;
  logic [CNT_W-1:0]   low_cnt_q;
  logic [CNT_W-1:0]   wait_cnt_q;
  logic [LEVEL_W-1:0] prim_q;
  logic [LEVEL_W-1:0] sec_q;
  logic               en_s;
  logic               shdn_req;
  logic               prim_fall;
  logic               sec_fall;
  logic               grp_clear;

  // Reset image of the link synchroniser: enable low, both pulse lines at idle high,
  // so the edge detector never sees a false fall when reset lets go
  localparam logic [2:0] LINK_IDLE = 3'h3;

  // A fall is a high in the history flop over a low in the second synchroniser flop
  function automatic logic fall_seen(input logic was_q, input logic now_q);
    return was_q & ~now_q;
  endfunction

  // Next current setting for one falling edge: off goes to full, else one step down
  // The 32nd step lands on off and the edge after it starts again at full scale,
  // so a host that lost count recovers by sending edges until the level wraps
  function automatic logic [LEVEL_W-1:0] step_level(input logic [LEVEL_W-1:0] cur);
    logic [LEVEL_W-1:0] nxt;
    nxt = (cur == LEVEL_OFF) ? LEVEL_FULL : cur - LEVEL_W'(1);  // [R6] [R7] [R8]
    return nxt;
  endfunction

  // Two-flop synchroniser for the three link lines
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_q <= LINK_IDLE;
      sync2_q <= LINK_IDLE;
    end else begin
      sync1_q <= {LINK.enable, LINK.secondary_group_pulse_n, LINK.primary_group_pulse_n};  // [R14]
      sync2_q <= sync1_q;
    end
  end

  // History flop for edge detection, fed only from the settled second stage
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prev_q <= LINK_IDLE;
    end else begin
      prev_q <= sync2_q;  // [R14]
    end
  end

  // Two-flop synchroniser for the regulation flag from the analog side
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      short1_q <= 1'h0;
      short2_q <= 1'h0;
    end else begin
      short1_q <= REG_SHORT;
      short2_q <= short1_q;
    end
  end

  // Settled enable and the falling edges of each group
  assign en_s      = sync2_q[2];
  assign prim_fall = fall_seen(prev_q[0], sync2_q[0]);  // [R14]
  assign sec_fall  = fall_seen(prev_q[1], sync2_q[1]);  // [R14]

  // Low-time counter on enable, saturating above the shutdown threshold
  // Saturation keeps a long low from wrapping back under the threshold
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_cnt_q <= '0;
    end else if (en_s) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q <= CNT_W'(SHDN_LOW)) begin
      low_cnt_q <= low_cnt_q + CNT_W'(1);  // [R14]
    end
  end

  // Tied inputs: only a long low shuts down; separate inputs: any low does
  // With tied lines every dimming pulse also drops enable, so only its length tells
  assign shdn_req = SINGLE_WIRE ? (low_cnt_q > CNT_W'(SHDN_LOW)) : ~en_s;  // [R9] [R12]

  // Conversion mode sequence
  // A flag that clears during the wait returns to 1x; 1.5x holds until shutdown,
  // since only a fresh start from shutdown runs the selection again
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      ST_SHDN: if (en_s) mode_d = ST_1X;  // [R3]
      ST_1X:   if (short2_q) mode_d = ST_WAIT;  // [R1]
      ST_WAIT: begin
        if (!short2_q) begin
          mode_d = ST_1X;
        end else if (wait_cnt_q >= CNT_W'(MODE_DELAY - 1)) begin
          mode_d = ST_15X;  // [R2]
        end
      end
      ST_15X:  mode_d = ST_15X;
      default: mode_d = ST_SHDN;
    endcase
    if (shdn_req) begin
      mode_d = ST_SHDN;  // [R9] [R12]
    end
  end

  // Mode register; reset lands in shutdown so enabling starts at 1x
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_q <= ST_SHDN;  // [R3]
    end else begin
      mode_q <= mode_d;
    end
  end

  // Delay counter for the 1x to 1.5x change
  // It counts only in the wait state, so a flag that blinks restarts the full delay
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wait_cnt_q <= '0;
    end else if (mode_q == ST_WAIT) begin
      wait_cnt_q <= wait_cnt_q + CNT_W'(1);  // [R2]
    end else begin
      wait_cnt_q <= '0;
    end
  end

  // Levels clear while shutdown is requested or held, so edges then are dropped
  // and the first edge after enabling always selects full scale
  assign grp_clear = shdn_req || (mode_q == ST_SHDN);  // [R13]

  // Primary group current setting
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prim_q <= LEVEL_OFF;  // [R13]
    end else if (grp_clear) begin
      prim_q <= LEVEL_OFF;  // [R12] [R13]
    end else if (prim_fall) begin
      prim_q <= step_level(prim_q);  // [R4] [R6] [R7] [R8]
    end
  end

  // Secondary group current setting, kept apart so neither group sees the other's edges
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sec_q <= LEVEL_OFF;  // [R13]
    end else if (grp_clear) begin
      sec_q <= LEVEL_OFF;  // [R12] [R13]
    end else if (sec_fall) begin
      sec_q <= step_level(sec_q);  // [R4]
    end
  end

  // Outputs
  // LED outputs are on whenever their group holds a non-zero setting
  assign PRIM_LEVEL            = prim_q;
  assign SEC_LEVEL             = sec_q;
  assign PRIMARY_LED_OUTPUTS   = {PRIM_LEDS{prim_q != LEVEL_OFF}};  // [R4]
  assign SECONDARY_LED_OUTPUTS = {SEC_LEDS{sec_q != LEVEL_OFF}};
  assign MODE_1P5X             = (mode_q == ST_15X);
  assign SHUTDOWN              = (mode_q == ST_SHDN);

endmodule

// ==== src/dim_host.sv ====
// Host end: turns enable, pulse and shutdown requests into link waveforms
`timescale 1ns/1ps
module dim_host
  import dim_pkg::*;
#(
  parameter int PULSE_LOW  = PULSE_LOW_CYC,
  parameter int PULSE_HIGH = PULSE_HIGH_CYC,
  parameter int SHDN_HOLD  = SHDN_HOLD_CYC
) (
  input  wire logic      CLK,
  input  wire logic      RST_N,
  dim_if.host            LINK,
  input  wire logic      SINGLE_WIRE,
  input  wire logic      REQ_VALID,
  input  op_e            REQ_OP,
  output logic           REQ_READY,
  output logic           ENABLED
);

  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_LOW  = 4'h2,
    H_HIGH = 4'h4,
    H_SHDN = 4'h8
  } host_e;

  host_e            st_q;
  logic [CNT_W-1:0] cnt_q;
  logic             en_q;
  logic             pr_q;
  logic             se_q;
  logic             take;

  assign REQ_READY = (st_q == H_IDLE);
  assign take      = REQ_VALID & REQ_READY;

  // Sequencer: a pulse is low then high for fixed times; shutdown holds low
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q  <= H_IDLE;
      cnt_q <= '0;
      en_q  <= 1'h0;
      pr_q  <= 1'h1;
      se_q  <= 1'h1;
    end else begin
      unique case (st_q)
        H_IDLE: begin
          cnt_q <= '0;
          if (take) begin
            unique case (REQ_OP)
              OP_ENABLE: begin
                en_q <= 1'h1;
                pr_q <= 1'h1;
                se_q <= 1'h1;
              end
              OP_PULSE_PR, OP_PULSE_SE: begin
                if (en_q) begin  // [R5]
                  pr_q <= ~(SINGLE_WIRE | (REQ_OP == OP_PULSE_PR));  // [R10]
                  se_q <= ~(SINGLE_WIRE | (REQ_OP == OP_PULSE_SE));
                  st_q <= H_LOW;
                end
              end
              OP_SHUTDOWN: begin
                en_q <= 1'h0;
                pr_q <= ~SINGLE_WIRE;  // [R10]
                se_q <= ~SINGLE_WIRE;
                st_q <= H_SHDN;
              end
            endcase
          end
        end
        H_LOW: begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (cnt_q >= CNT_W'(PULSE_LOW - 1)) begin  // [R11]
            cnt_q <= '0;
            pr_q  <= 1'h1;
            se_q  <= 1'h1;
            st_q  <= H_HIGH;
          end
        end
        H_HIGH: begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (cnt_q >= CNT_W'(PULSE_HIGH - 1)) begin
            cnt_q <= '0;
            st_q  <= H_IDLE;
          end
        end
        H_SHDN: begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (cnt_q >= CNT_W'(SHDN_HOLD - 1)) begin  // [R12]
            cnt_q <= '0;
            st_q  <= H_IDLE;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // Single-wire pulses also pull enable low for the pulse time
  assign LINK.enable                  = en_q & ~(SINGLE_WIRE & (st_q == H_LOW));  // [R10]
  assign LINK.primary_group_pulse_n   = pr_q;
  assign LINK.secondary_group_pulse_n = se_q;
  assign ENABLED                      = en_q;

endmodule

// ==== testbench/dim_checker.sv ====
// Assertions on the dimming link lines and the device outputs
`timescale 1ns/1ps
module dim_checker
  import dim_pkg::*;
#(
  parameter int SHDN_LOW = 40  // Shutdown threshold in cycles, as the bench sets the device
) (
  input wire logic                 CLK,
  input wire logic                 RST_N,
  input wire logic                 enable,
  input wire logic                 primary_group_pulse_n,
  input wire logic                 secondary_group_pulse_n,
  input wire logic                 SINGLE_WIRE,
  input wire logic [LEVEL_W-1:0]   PRIM_LEVEL,
  input wire logic [LEVEL_W-1:0]   SEC_LEVEL,
  input wire logic [PRIM_LEDS-1:0] PRIMARY_LED_OUTPUTS,
  input wire logic                 SHUTDOWN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [7:0] low_q;
  // Counts consecutive low cycles of the tied line
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_q <= 8'h00;
    end else if (enable || !SINGLE_WIRE) begin
      low_q <= 8'h00;
    end else if (low_q != 8'hff) begin
      low_q <= low_q + 8'h01;
    end
  end
  // A tied-line low is either a short dimming pulse or a shutdown-length hold
  property p_pulse_short;
    SINGLE_WIRE && $rose(enable) |-> low_q < 8'h09 || low_q > SHDN_LOW;
  endproperty
  a_pulse_short: assert property (p_pulse_short) else $error("pulse low too long");
  property p_enable_first;
    $fell(primary_group_pulse_n) && !SINGLE_WIRE |-> enable;
  endproperty
  a_enable_first: assert property (p_enable_first) else $error("pulse while disabled");
  property p_tied;
    SINGLE_WIRE |-> primary_group_pulse_n == secondary_group_pulse_n;
  endproperty
  a_tied: assert property (p_tied) else $error("tied lines differ");
  property p_dual_off;
    !SINGLE_WIRE && $fell(enable) |-> ##[1:4] SHUTDOWN;
  endproperty
  a_dual_off: assert property (p_dual_off) else $error("enable low without shutdown");
  property p_long_low;
    low_q == SHDN_LOW + 8 |-> SHUTDOWN;
  endproperty
  a_long_low: assert property (p_long_low) else $error("long low without shutdown");
  property p_short_low;
    SINGLE_WIRE && !SHUTDOWN && $fell(enable) |-> !SHUTDOWN [*8];
  endproperty
  a_short_low: assert property (p_short_low) else $error("short low shut down");
  property p_step;
    $fell(primary_group_pulse_n) && !SINGLE_WIRE && !SHUTDOWN
      |-> ##4 PRIM_LEVEL == $past(PRIM_LEVEL, 4) - 5'h01;
  endproperty
  a_step: assert property (p_step) else $error("level step wrong");
  property p_clear;
    SHUTDOWN [*2] |-> PRIM_LEVEL == LEVEL_OFF && SEC_LEVEL == LEVEL_OFF;
  endproperty
  a_clear: assert property (p_clear) else $error("level kept in shutdown");
  property p_led;
    PRIMARY_LED_OUTPUTS == {PRIM_LEDS{PRIM_LEVEL != LEVEL_OFF}};
  endproperty
  a_led: assert property (p_led) else $error("primary outputs wrong");
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench joining the dimming host and device
`timescale 1ns/1ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %0h seen %0h", n, e, a); end end
module tb_top
  import dim_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       single_wire = 1'b0;
  logic       reg_short = 1'b0;
  logic       req_valid = 1'b0;
  op_e        req_op = OP_ENABLE;
  logic       req_ready, enabled, mode_1p5x, shutdown;
  logic [4:0] prim_level, sec_level;
  logic [3:0] prim_leds;
  logic [1:0] sec_leds;
  int         fail_count = 0;
  int         samples_checked = 0;
  // Clock at 40 MHz
  always #12.5 clk = ~clk;
  dim_if link();
  dim_host #(.PULSE_LOW(4), .PULSE_HIGH(4), .SHDN_HOLD(60)) dim_host_inst (.CLK(clk),
    .RST_N(rst_n), .LINK(link.host), .SINGLE_WIRE(single_wire), .REQ_VALID(req_valid),
    .REQ_OP(req_op), .REQ_READY(req_ready), .ENABLED(enabled));
  dim_device #(.MODE_DELAY(20), .SHDN_LOW(40)) dim_device_inst (.CLK(clk), .RST_N(rst_n),
    .LINK(link.dev), .SINGLE_WIRE(single_wire), .REG_SHORT(reg_short),
    .PRIM_LEVEL(prim_level), .SEC_LEVEL(sec_level), .PRIMARY_LED_OUTPUTS(prim_leds),
    .SECONDARY_LED_OUTPUTS(sec_leds), .MODE_1P5X(mode_1p5x), .SHUTDOWN(shutdown));
  dim_checker dim_checker_inst (.CLK(clk), .RST_N(rst_n),
    .enable(link.enable), .primary_group_pulse_n(link.primary_group_pulse_n),
    .secondary_group_pulse_n(link.secondary_group_pulse_n), .SINGLE_WIRE(single_wire),
    .PRIM_LEVEL(prim_level), .SEC_LEVEL(sec_level), .PRIMARY_LED_OUTPUTS(prim_leds),
    .SHUTDOWN(shutdown));
  // Reset for 12 cycles with the chosen wiring mode
  task automatic do_reset(input logic sw);
    rst_n <= 1'b0;
    single_wire <= sw;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask
  // One host request, then wait until idle and the device has settled
  task automatic req(input op_e op);
    int n;
    req_valid <= 1'b1;
    req_op <= op;
    n = 0;
    do begin @(posedge clk); n++; end while (!req_ready && n < 200);
    req_valid <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end while (!req_ready && n < 200);
    if (!req_ready) begin
      fail_count++;
      $display("ERROR req_ready expected 1 seen 0");
    end
    repeat (6) @(posedge clk);
  endtask
  // Dropped early pulse, full count down and wrap, group independence
  task automatic t_steps;
    logic [4:0] e;
    req(OP_PULSE_PR);
    `CHK("early", 5'h00, prim_level)
    `CHK("enabled", 1'b0, enabled)
    req(OP_ENABLE);
    `CHK("enabled", 1'b1, enabled)
    `CHK("mode", 1'b0, mode_1p5x)
    for (int i = 1; i <= 33; i++) begin
      req(OP_PULSE_PR);
      e = LEVEL_FULL - 5'(i - 1);
      `CHK("prim", e, prim_level)
      `CHK("leds", {4{e != 5'h00}}, prim_leds)
    end
    `CHK("sec", 5'h00, sec_level)
    req(OP_PULSE_SE);
    `CHK("sec", LEVEL_FULL, sec_level)
    `CHK("sleds", 2'h3, sec_leds)
  endtask
  // Mode change after the delay, shutdown, restart in 1x from off
  task automatic t_mode;
    reg_short <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK("mode", 1'b0, mode_1p5x)
    repeat (20) @(posedge clk);
    `CHK("mode", 1'b1, mode_1p5x)
    reg_short <= 1'b0;
    req(OP_SHUTDOWN);
    `CHK("shdn", 1'b1, shutdown)
    `CHK("prim", 5'h00, prim_level)
    `CHK("enabled", 1'b0, enabled)
    req(OP_ENABLE);
    `CHK("mode", 1'b0, mode_1p5x)
    req(OP_PULSE_SE);
    `CHK("sec", LEVEL_FULL, sec_level)
  endtask
  // Tied lines: short pulses step both groups, long low shuts down
  task automatic t_single;
    do_reset(1'b1);
    req(OP_ENABLE);
    req(OP_PULSE_PR);
    `CHK("prim", LEVEL_FULL, prim_level)
    `CHK("sec", LEVEL_FULL, sec_level)
    req(OP_PULSE_SE);
    `CHK("prim", 5'h1e, prim_level)
    `CHK("shdn", 1'b0, shutdown)
    req(OP_SHUTDOWN);
    `CHK("shdn", 1'b1, shutdown)
    `CHK("prim", 5'h00, prim_level)
  endtask
  // Prints the counts and the verdict, then ends the run
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    do_reset(1'b0);
    t_steps();
    t_mode();
    t_single();
    results();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end
endmodule
